// >>> common/vlc_pkg.sv
// package: register map, field layout, state codes and timing constants of the link config block
package vlc_pkg;

    // register byte offsets on the wishbone slave
    localparam logic [3:0] VLC_OFF_DELAY   = 4'h0;   // transceiver_delay_ctrl
    localparam logic [3:0] VLC_OFF_CTRL1   = 4'h4;   // link_control_one
    localparam logic [3:0] VLC_OFF_STATE   = 4'h8;   // state_vector_reg
    localparam logic [3:0] VLC_OFF_EVENT   = 4'hC;   // transmit, receiver state and irq status

    // transceiver_delay_ctrl fields
    localparam int VLC_DLY_XCVR_BIT = 7;             // onboard_xcvr_select
    localparam int VLC_DLY_POL_BIT  = 6;             // rx_polarity_sel
    localparam int VLC_DLY_OFS_LSB  = 0;             // delay_offset_field [3:0]
    localparam logic [7:0] VLC_DLY_RESET = 8'h47;    // 16 us, non-inverted rx, off-chip

    // link_control_one fields
    localparam int VLC_C1_IGN_BIT  = 7;              // ignore_frame_bit
    localparam int VLC_C1_TB_BIT   = 6;              // timebase_select
    localparam int VLC_C1_RATE_LSB = 2;              // rate_div_hi/lo
    localparam int VLC_C1_IE_BIT   = 1;              // irq_enable_bit
    localparam int VLC_C1_WCG_BIT  = 0;              // wait_clock_gate
    localparam logic [7:0] VLC_C1_RESET = 8'h00;

    // delay compensation base in microseconds
    localparam logic [4:0] VLC_DELAY_BASE_US = 5'd9;

    // state vector codes
    localparam logic [7:0] VLC_SV_IDLE    = 8'h00;
    localparam logic [7:0] VLC_SV_CRC     = 8'h18;
    localparam logic [7:0] VLC_SV_INVALID = 8'h1C;

    // crc residue of a good frame
    localparam logic [7:0] VLC_CRC_RESIDUE = 8'hC4;

    // crystal clock at 200 MHz: period in ns
    localparam int VLC_CLK_NS = 5;

    // receiver state machine, gray coded along idle -> hunt -> receive
    typedef enum logic [1:0] {
        VLC_RX_IDLE = 2'b00,
        VLC_RX_WAIT = 2'b01,
        VLC_RX_RECV = 2'b11,
        VLC_RX_XMIT = 2'b10
    } vlc_rx_type;

    // symbol events from the symbol decoder
    typedef struct packed {
        logic sof;          // start of frame seen
        logic brk;          // break symbol seen
        logic eod;          // end of data seen
        logic bad_sym;      // invalid bit or noise
        logic frame_err;    // eod/eof off a byte boundary
        logic byte_done;    // a data byte completed
    } vlc_sym_type;

    // transmitter request and observations
    typedef struct packed {
        logic start;        // software asks to start a frame
        logic bus_active;   // bus seen dominant
        logic drive_fail;   // driven active but bus stayed passive
        logic tx_bad;       // own frame has bad bits or misaligned framing
    } vlc_tx_type;

endpackage

// >>> rtl/vlc_link_cfg.sv
// design: configuration, timebase divider and error response of the vpw link controller
`timescale 1ns/100ps

// How it works
// R1: bad own frame stops transmit, flags invalid
// R2: crc mismatch flags crc, waits for sof
// R3: noise during transmit aborts, flags invalid
// R4: framing error flags invalid, waits for sof
// R5: no transmit start while bus held active
// R6: ground short reports invalid symbol code
// R7: break flags invalid, waits for sof
// R8: delay compensation resets to 16 us
// R9: delay is 9 us plus offset field
// R10: delay register takes first write only
// R11: xcvr select bit chooses onboard transceiver
// R12: polarity bit 0 inverts receive pin
// R13: ignore bit disables receiver, masks, clears status
// R14: ignore bit clears on sof or break
// R15: timebase select picks binary or integer rate
// R16: rate field divides crystal by 1,2,4,8
// R17: rate field takes first write only
// R18: software picks rate giving nominal timebase
// R19: irq enable gates run mode requests only
// R20: request holds until all sources cleared
// R21: wait clock bit stops clocks in wait
// R22: software may poll state vector instead
// R23: crc error when residue differs from c4
// R24: reading state vector clears invalid flag
// R25: invalid code 1c, crc error code 18
// R26: timebase is a one-cycle enable pulse
module vlc_link_cfg (
    // clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    // wishbone slave
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [3:0]           wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    output logic                      wb_err_o,
    // receive pin
    input  wire logic                 rx_pin_i,
    // symbol and transmit events
    input  wire vlc_pkg::vlc_sym_type sym_i,
    input  wire vlc_pkg::vlc_tx_type  tx_i,
    input  wire logic [7:0]           crc_i,
    // cpu power modes
    input  wire logic                 cpu_wait_i,
    input  wire logic                 wake_i,
    // link path outputs
    output logic                      rx_data_o,
    output logic                      tx_enable_o,
    output logic                      tx_abort_o,
    // timebase and configuration
    output logic                      tb_tick_o,
    output logic                      timebase_bin_o,
    output logic [4:0]                delay_us_o,
    output logic                      onboard_xcvr_o,
    output logic                      clk_run_o,
    // interrupt request
    output logic                      irq_o
);
    import vlc_pkg::*;

    // only config, timebase and error response live here;
    // symbol timing and data path feed the event ports

    ////////////////////////////////////////////////////////////////////////////
    // registers and state
    // configuration
    logic [7:0]  delay_reg;
    logic        delay_locked;
    logic [7:0]  ctrl1;
    logic        rate_locked;
    // status
    logic [7:0]  state_vec;
    logic        flag_invalid;
    logic        flag_crc;
    // timebase and sequencing
    logic [2:0]  div_cnt;
    logic        tb_tick;
    logic        transmitting;
    vlc_rx_type  rx_state;

    // decode and derived controls
    logic        wr_hit;
    logic        rd_hit;
    logic        ignore;
    logic        clk_run;
    logic        ev_invalid;
    logic        ev_crc;
    logic        sv_read;
    logic [2:0]  div_max;
    logic [1:0]  rate;

    // bus decode; a classic single cycle answered one cycle after strobe
    // reads are taken at the strobe edge so data stands with ack;
    // writes land at the edge where the master samples ack,
    // so a cycle abandoned before ack changes nothing
    assign wr_hit  = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
    assign rd_hit  = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && !wb_err_o;
    assign sv_read = rd_hit && (wb_adr_i == VLC_OFF_STATE);
    assign ignore  = ctrl1[VLC_C1_IGN_BIT];
    assign rate    = ctrl1[VLC_C1_RATE_LSB +: 2];

    // internal clocks stop in cpu wait only when the gate bit is set
    assign clk_run = !(cpu_wait_i && ctrl1[VLC_C1_WCG_BIT]);  // R21

    ////////////////////////////////////////////////////////////////////////////
    // wishbone acknowledge; unmapped offsets get err instead of ack
    // one-cycle pulses; the !ack/!err terms keep a held
    // strobe from being answered twice
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o &&
                        (wb_adr_i == VLC_OFF_DELAY || wb_adr_i == VLC_OFF_CTRL1 ||
                         wb_adr_i == VLC_OFF_STATE || wb_adr_i == VLC_OFF_EVENT);
            wb_err_o <= wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o &&
                        !(wb_adr_i == VLC_OFF_DELAY || wb_adr_i == VLC_OFF_CTRL1 ||
                          wb_adr_i == VLC_OFF_STATE || wb_adr_i == VLC_OFF_EVENT);
        end
    end


    // read data registered with the ack; upper bits read zero
    // a state vector read also clears the flag it shows
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (rd_hit) begin
            case (wb_adr_i)
                VLC_OFF_DELAY: wb_dat_o <= {24'h00_0000, delay_reg};  // R10
                VLC_OFF_CTRL1: wb_dat_o <= {24'h00_0000, ctrl1};
                VLC_OFF_STATE: wb_dat_o <= {24'h00_0000, state_vec};  // R22
                VLC_OFF_EVENT: wb_dat_o <= {24'h00_0000, 4'h0, transmitting, rx_state, irq_o};
                default:       wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // delay compensation: only the first write after reset is kept
    // later writes are acked but change nothing;
    // a new delay needs a reset first
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            delay_reg    <= VLC_DLY_RESET;  // R8
            delay_locked <= 1'b0;
        end else if (wr_hit && wb_adr_i == VLC_OFF_DELAY && !delay_locked) begin
            delay_reg    <= wb_dat_i[7:0];  // R10
            delay_locked <= 1'b1;
        end
    end


    // compensated delay and transceiver routing
    // polarity 0 suits transceivers that invert the bus
    assign delay_us_o     = VLC_DELAY_BASE_US + {1'b0, delay_reg[VLC_DLY_OFS_LSB +: 4]};  // R9
    assign onboard_xcvr_o = delay_reg[VLC_DLY_XCVR_BIT];  // R11
    assign rx_data_o      = delay_reg[VLC_DLY_POL_BIT] ? rx_pin_i : !rx_pin_i;  // R12

    ////////////////////////////////////////////////////////////////////////////
    // control register one; rate field locks after its first write, ignore bit self clears
    // the rate locks even if that write leaves it 0;
    // set the rate before any other control bit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl1       <= VLC_C1_RESET;
            rate_locked <= 1'b0;
        end else begin
            if (wr_hit && wb_adr_i == VLC_OFF_CTRL1) begin
                ctrl1[VLC_C1_IGN_BIT] <= wb_dat_i[VLC_C1_IGN_BIT];
                ctrl1[VLC_C1_TB_BIT]  <= wb_dat_i[VLC_C1_TB_BIT];
                ctrl1[VLC_C1_IE_BIT]  <= wb_dat_i[VLC_C1_IE_BIT];
                ctrl1[VLC_C1_WCG_BIT] <= wb_dat_i[VLC_C1_WCG_BIT];
                if (!rate_locked) begin
                    ctrl1[VLC_C1_RATE_LSB +: 2] <= wb_dat_i[VLC_C1_RATE_LSB +: 2];  // R17
                    rate_locked                 <= 1'b1;
                end
            end
            // sof or break re-enables the receiver; it wins over a same-cycle write
            if (ignore && clk_run && (sym_i.sof || sym_i.brk)) begin
                ctrl1[VLC_C1_IGN_BIT] <= 1'b0;  // R14
            end
        end
    end


    // timebase select straight from the register; clock run also follows cpu wait
    assign timebase_bin_o = ctrl1[VLC_C1_TB_BIT];  // R15
    assign clk_run_o      = clk_run;

    ////////////////////////////////////////////////////////////////////////////
    // timebase divider: a single-cycle enable, no derived clock
    // an enable keeps every flop on clk_i, so no
    // clock needs its own constraints or crossing
    always_comb begin
        case (rate)
            2'b00:   div_max = 3'd0;  // R16
            2'b01:   div_max = 3'd1;
            2'b10:   div_max = 3'd3;
            2'b11:   div_max = 3'd7;
            default: div_max = 3'd0;
        endcase
    end


    // count holds while the clocks stand
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_cnt <= 3'd0;
            tb_tick <= 1'b0;
        end else if (!clk_run) begin
            tb_tick <= 1'b0;  // R21
        end else if (div_cnt >= div_max) begin
            div_cnt <= 3'd0;
            tb_tick <= 1'b1;  // R26
        end else begin
            div_cnt <= div_cnt + 3'd1;
            tb_tick <= 1'b0;
        end
    end

    assign tb_tick_o = tb_tick;

    ////////////////////////////////////////////////////////////////////////////
    // error detection; nothing is recorded while ignoring or while clocks stand
    // events are one-cycle pulses; one that comes
    // while clocks stand is lost, as gated logic would
    assign ev_invalid = clk_run && !ignore &&
                        ((transmitting && (tx_i.tx_bad || sym_i.bad_sym || tx_i.drive_fail)) ||  // R1 R3 R6
                         (rx_state == VLC_RX_RECV && (sym_i.frame_err || sym_i.bad_sym)) ||  // R4
                         (rx_state != VLC_RX_IDLE && sym_i.brk));  // R7
    assign ev_crc     = clk_run && !ignore && rx_state == VLC_RX_RECV && sym_i.eod &&
                        (crc_i != VLC_CRC_RESIDUE);  // R2 R23

    // receiver / transmitter sequencing
    // after an error the receiver waits for a new sof;
    // an eod seen there is ignored, so no stale crc flag
    // a bus short to supply blocks any start
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_state     <= VLC_RX_IDLE;
            transmitting <= 1'b0;
        end else if (ignore) begin
            rx_state     <= VLC_RX_WAIT;  // R13
            transmitting <= 1'b0;
        end else if (clk_run) begin
            case (rx_state)
                VLC_RX_IDLE: begin
                    if (sym_i.sof) begin
                        rx_state <= VLC_RX_RECV;
                    end else if (tx_i.start && !tx_i.bus_active) begin
                        rx_state     <= VLC_RX_XMIT;  // R5
                        transmitting <= 1'b1;
                    end
                end
                VLC_RX_WAIT: begin
                    if (sym_i.sof) begin
                        rx_state <= VLC_RX_RECV;  // R2 R4 R7
                    end
                end
                VLC_RX_RECV: begin
                    if (ev_invalid || ev_crc) begin
                        rx_state <= VLC_RX_WAIT;  // R2 R4
                    end else if (sym_i.eod) begin
                        rx_state <= VLC_RX_IDLE;
                    end
                end
                VLC_RX_XMIT: begin
                    if (ev_invalid) begin
                        rx_state     <= VLC_RX_WAIT;  // R1 R3
                        transmitting <= 1'b0;
                    end else if (sym_i.eod) begin
                        rx_state     <= VLC_RX_IDLE;
                        transmitting <= 1'b0;
                    end
                end
                default: begin
                    rx_state     <= VLC_RX_IDLE;
                    transmitting <= 1'b0;
                end
            endcase
        end
    end

    // enable drops in the error cycle so the driver stops at once
    assign tx_enable_o = transmitting && !ev_invalid;
    assign tx_abort_o  = transmitting && ev_invalid;  // R1 R3

    ////////////////////////////////////////////////////////////////////////////
    // sticky flags; a new event wins over the read that clears it
    // ignore forces both low; a read clears only the flag it showed
    always_ff @(posedge clk_i) begin
        if (rst_i || ignore) begin
            flag_invalid <= 1'b0;  // R13
            flag_crc     <= 1'b0;
        end else begin
            if (ev_invalid) begin
                flag_invalid <= 1'b1;
            end else if (sv_read && state_vec == VLC_SV_INVALID) begin
                flag_invalid <= 1'b0;  // R24
            end
            if (ev_crc) begin
                flag_crc <= 1'b1;
            end else if (sv_read && state_vec == VLC_SV_CRC) begin
                flag_crc <= 1'b0;
            end
        end
    end


    // state vector shows the highest pending source
    // invalid symbol outranks a crc error
    always_comb begin
        if (flag_invalid) begin
            state_vec = VLC_SV_INVALID;  // R25
        end else if (flag_crc) begin
            state_vec = VLC_SV_CRC;  // R25
        end else begin
            state_vec = VLC_SV_IDLE;
        end
    end


    // run-mode requests gated by enable; wake-up bypasses it, never while ignoring
    // requests pending when enable clears stay flagged and come back when it is set
    assign irq_o = !ignore && (((flag_invalid || flag_crc) && ctrl1[VLC_C1_IE_BIT]) || wake_i);  // R19 R20

endmodule

// >>> test/vlc_bus_model.sv
// partner: transceiver and far bus nodes, turning bench commands into link events
`timescale 1ns/100ps
module vlc_bus_model (
    // bench control
    input  wire logic           clk_i,
    input  wire logic           rst_i,
    input  wire logic [3:0]     cmd_i,
    input  wire logic           short_vdd_i,
    // toward the block
    output vlc_pkg::vlc_sym_type sym_o,
    output vlc_pkg::vlc_tx_type  tx_o,
    output logic [7:0]          crc_o,
    output logic                rx_pin_o
);
    import vlc_pkg::*;
    // one-cycle pulses; a shorted bus stays active as a level
    always_ff @(posedge clk_i) begin
        sym_o <= {cmd_i == 4'd5, cmd_i == 4'd4, cmd_i[3:1] == 3'd3, cmd_i == 4'd2, cmd_i == 4'd3, 1'b0};
        tx_o  <= {cmd_i == 4'd1, short_vdd_i, cmd_i == 4'd8, cmd_i == 4'd9};
    end
    // residue is only meaningful at end of data, so it wanders otherwise
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            crc_o    <= 8'h00;
            rx_pin_o <= 1'b0;
        end else begin
            crc_o    <= (cmd_i == 4'd7) ? 8'hC4 : (cmd_i == 4'd6) ? 8'h3A : ~crc_o;
            rx_pin_o <= ~rx_pin_o;
        end
    end
endmodule

// >>> test/vlc_link_cfg_props.sv
// checker: concurrent assertions on the ports of the link config block
`timescale 1ns/100ps
module vlc_link_cfg_props (
    // clock, reset and bus
    input wire logic                 clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o,
    input wire logic [3:0]           wb_adr_i, wb_sel_i,
    // link side
    input wire logic                 rx_pin_i, rx_data_o, cpu_wait_i, clk_run_o, tx_enable_o, tx_abort_o,
    input wire vlc_pkg::vlc_sym_type sym_i,
    input wire vlc_pkg::vlc_tx_type  tx_i,
    input wire logic [4:0]           delay_us_o
);
    import vlc_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic dly_done;
    ////////////////////////////////////////
    // remembers that the one permitted delay write has landed; later writes must not move the delay
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dly_done <= 1'b0;
        end else if (wb_ack_o && wb_we_i && wb_adr_i == VLC_OFF_DELAY && wb_sel_i[0]) begin
            dly_done <= 1'b1;
        end
    end
    ////////////////////////////////////////
    property p_answer; wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o || wb_err_o; endproperty
    a_answer: assert property (p_answer) else $error("bus request not answered on the next edge");
    property p_dly_rst; $fell(rst_i) |-> delay_us_o == 5'd16; endproperty
    a_dly_rst: assert property (p_dly_rst) else $error("delay not 16 us after reset");
    property p_dly_range; delay_us_o >= 5'd9 && delay_us_o <= 5'd24; endproperty
    a_dly_range: assert property (p_dly_range) else $error("delay outside 9 to 24 us");
    property p_dly_once; dly_done |=> $stable(delay_us_o); endproperty
    a_dly_once: assert property (p_dly_once) else $error("delay moved after its first write");
    // polarity only changes at a register write, so pin and output keep their relation
    property p_rx_pol; !$past(wb_ack_o) |-> $stable(rx_data_o ^ rx_pin_i); endproperty
    a_rx_pol: assert property (p_rx_pol) else $error("receive output lost its pin relation");
    property p_wait_clk; !cpu_wait_i |-> clk_run_o; endproperty
    a_wait_clk: assert property (p_wait_clk) else $error("clocks stopped outside wait mode");
    property p_noise; sym_i.bad_sym |-> !tx_enable_o; endproperty
    a_noise: assert property (p_noise) else $error("transmit still enabled during noise");
    property p_tx_bad; tx_i.tx_bad |-> !tx_enable_o; endproperty
    a_tx_bad: assert property (p_tx_bad) else $error("transmit still enabled on a bad own frame");
    property p_abort_end; tx_abort_o |=> !tx_enable_o [*2]; endproperty
    a_abort_end: assert property (p_abort_end) else $error("transmit resumed after an abort");
    property p_start; $rose(tx_enable_o) |-> $past(tx_i.start) && !$past(tx_i.bus_active); endproperty
    a_start: assert property (p_start) else $error("transmit began without a start on a passive bus");
endmodule
bind vlc_link_cfg vlc_link_cfg_props vlc_link_cfg_props_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_ack_o, .wb_err_o, .wb_adr_i, .wb_sel_i, .rx_pin_i, .rx_data_o, .cpu_wait_i, .clk_run_o, .tx_enable_o,
    .tx_abort_o, .sym_i, .tx_i, .delay_us_o);

// >>> test/vlc_link_cfg_test.sv
// bench: registers, timebase and error responses of the link config block
`timescale 1ns/100ps
module vlc_link_cfg_test;
    import vlc_pkg::*;
    logic        clk_i = 1'b0, rst_i = 1'b1, cpu_wait_i = 1'b0, wake_i = 1'b0, short_vdd = 1'b0;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, er, ab;
    logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'hF, cmd = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rd;
    logic [7:0]  crc_i;
    logic [4:0]  delay_us_o;
    logic        wb_ack_o, wb_err_o, rx_pin_i, rx_data_o, tx_enable_o, tx_abort_o, tb_tick_o;
    logic        timebase_bin_o, onboard_xcvr_o, clk_run_o, irq_o;
    vlc_sym_type sym_i;
    vlc_tx_type  tx_i;
    int          n_fail = 0, n_checks = 0, cyc_n = 0, cnt;
    vlc_link_cfg vlc_link_cfg_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .wb_err_o, .rx_pin_i, .sym_i, .tx_i, .crc_i, .cpu_wait_i, .wake_i, .rx_data_o,
        .tx_enable_o, .tx_abort_o, .tb_tick_o, .timebase_bin_o, .delay_us_o, .onboard_xcvr_o, .clk_run_o, .irq_o);
    vlc_bus_model vlc_bus_model_i (.clk_i, .rst_i, .cmd_i(cmd), .short_vdd_i(short_vdd), .sym_o(sym_i),
        .tx_o(tx_i), .crc_o(crc_i), .rx_pin_o(rx_pin_i));
    ////////////////////////////////////////
    // 200 MHz crystal clock
    initial forever #2.5 clk_i = ~clk_i;
    // hang guard: the full run needs under a thousand cycles
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n == 10000) begin
            n_fail++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic do_reset();
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask
    // classic cycle: hold everything until ack or err is sampled high, take data at that edge
    task automatic wb(input logic we, input logic [3:0] adr, input logic [7:0] dat);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= {24'h00_0000, dat};
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1) begin
            @(posedge clk_i);
        end
        rd = wb_dat_o;
        er = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        #1;
    endtask
    // one link event; abort is comb, so it is caught in the cycle the event stands
    task automatic ev(input logic [3:0] c);
        @(posedge clk_i);
        cmd <= c;
        @(posedge clk_i);
        cmd <= 4'h0;
        #1 ab = tx_abort_o;
        @(posedge clk_i);
        #1;
    endtask
    task automatic err_case(input logic [3:0] c, input logic tx, input logic [7:0] sv);
        do_reset();
        wb(1'b1, VLC_OFF_CTRL1, 8'h02);
        ev(tx ? 4'd1 : 4'd5);
        chk(tx_enable_o, tx);
        ev(c);
        chk(ab, tx);
        chk(irq_o, sv != 8'h00);
        wb(1'b0, VLC_OFF_STATE, 8'h00);
        chk(rd, sv);
        wb(1'b0, VLC_OFF_STATE, 8'h00);
        chk(rd, 32'h0000_0000);
        chk(irq_o, 1'b0);
    endtask
    ////////////////////////////////////////
    task automatic t_regs();
        wb(1'b0, VLC_OFF_DELAY, 8'h00);
        chk(rd, 32'h0000_0047);
        chk(delay_us_o, 5'd16);
        wb(1'b0, VLC_OFF_CTRL1, 8'h00);
        chk(rd, 32'h0000_0000);
        wb(1'b0, 4'h2, 8'h00);
        chk(er, 1'b1);
        wb(1'b1, VLC_OFF_DELAY, 8'h80);
        chk(onboard_xcvr_o, 1'b1);
    endtask
    task automatic t_delay();
        for (int i = 0; i < 16; i++) begin
            do_reset();
            wb(1'b1, VLC_OFF_DELAY, {1'b0, i[0], 2'b00, i[3:0]});
            chk(delay_us_o, 9 + i);
            chk(onboard_xcvr_o, 1'b0);
            chk(rx_data_o, rx_pin_i ^ !i[0]);
        end
        wb(1'b1, VLC_OFF_DELAY, 8'hC0);
        wb(1'b0, VLC_OFF_DELAY, 8'h00);
        chk(rd, 32'h0000_004F);
        chk(delay_us_o, 5'd24);
    endtask
    task automatic t_rate();
        for (int r = 0; r < 4; r++) begin
            do_reset();
            wb(1'b1, VLC_OFF_CTRL1, {1'b0, r[0], 2'b00, r[1:0], 2'b00});
            chk(timebase_bin_o, r[0]);
            repeat (8) @(posedge clk_i);
            cnt = 0;
            repeat (64) begin
                @(posedge clk_i);
                cnt += tb_tick_o;
            end
            chk(cnt, 64 >> r);
            wb(1'b1, VLC_OFF_CTRL1, {4'h0, ~r[1:0], 2'b00});
            wb(1'b0, VLC_OFF_CTRL1, 8'h00);
            chk(rd, {28'h000_0000, r[1:0], 2'b00});
        end
    endtask
    task automatic t_wait();
        wb(1'b1, VLC_OFF_CTRL1, 8'h01);
        @(posedge clk_i);
        cpu_wait_i <= 1'b1;
        #1 chk(clk_run_o, 1'b0);
        wb(1'b1, VLC_OFF_CTRL1, 8'h00);
        chk(clk_run_o, 1'b1);
        @(posedge clk_i);
        cpu_wait_i <= 1'b0;
    endtask
    task automatic t_errs();
        err_case(4'd2, 1'b1, 8'h1C);
        err_case(4'd9, 1'b1, 8'h1C);
        err_case(4'd8, 1'b1, 8'h1C);
        err_case(4'd4, 1'b0, 8'h1C);
        err_case(4'd6, 1'b0, 8'h18);
        err_case(4'd7, 1'b0, 8'h00);
        err_case(4'd3, 1'b0, 8'h1C);
        ev(4'd6);
        wb(1'b0, VLC_OFF_STATE, 8'h00);
        chk(rd, 32'h0000_0000);
    endtask
    task automatic t_short();
        do_reset();
        @(posedge clk_i);
        short_vdd <= 1'b1;
        ev(4'd1);
        chk(tx_enable_o, 1'b0);
        @(posedge clk_i);
        short_vdd <= 1'b0;
        ev(4'd1);
        chk(tx_enable_o, 1'b1);
    endtask
    // ignore set mid-frame hides a framing error; sof ends the ignoring
    task automatic t_ignore();
        do_reset();
        wb(1'b1, VLC_OFF_CTRL1, 8'h02);
        ev(4'd5);
        wb(1'b1, VLC_OFF_CTRL1, 8'h82);
        ev(4'd3);
        chk(irq_o, 1'b0);
        wb(1'b0, VLC_OFF_STATE, 8'h00);
        chk(rd, 32'h0000_0000);
        ev(4'd5);
        wb(1'b0, VLC_OFF_CTRL1, 8'h00);
        chk(rd, 32'h0000_0002);
        ev(4'd4);
        chk(irq_o, 1'b1);
    endtask
    task automatic t_poll();
        do_reset();
        wb(1'b1, VLC_OFF_CTRL1, 8'h00);
        ev(4'd5);
        ev(4'd4);
        chk(irq_o, 1'b0);
        @(posedge clk_i);
        wake_i <= 1'b1;
        #1 chk(irq_o, 1'b1);
        @(posedge clk_i);
        wake_i <= 1'b0;
        wb(1'b0, VLC_OFF_STATE, 8'h00);
        chk(rd, 32'h0000_001C);
    endtask
    ////////////////////////////////////////
    initial begin
        do_reset();
        t_regs();
        t_delay();
        t_rate();
        t_wait();
        t_errs();
        t_short();
        t_ignore();
        t_poll();
        conclude();
    end
endmodule
